// ==== verilog/aic_input_control.sv ====
// Input board control: latches, sample clock, trigger delay and detector.
// Notes on behaviour
// R1 - Divide 100 MHz by decades to 10 Hz; decade_select picks one stage.
// R2 - prescale_select passes chosen decade undivided, halved or divided by five.
// R3 - Processor presets the delay counter with ones complement of the count.
// R4 - Write 5 loads delay low byte, write 6 loads high byte.
// R5 - Trigger source selects rising or falling edge of data or external input.
// R6 - dot_detect_enable high for analog dot detection, low for digital glitches.
// R7 - With dot_detect_enable high comparators are strobed by sample clock.
// R8 - Processor grounds inputs and searches threshold values to measure offsets.
// R9 - Processor flags an input uncalibrated beyond fifty millivolts offset.
// R10 - Processor sets each threshold to a tenth of request plus offset.
// R11 - Processor keeps hold switches low while writing the DAC code.
// R12 - Processor pulses a hold switch after settling to charge its capacitor.
// R13 - Processor repeats the load and pulse cycle for all thresholds.
// R14 - DAC code is offset binary, 0x800 is zero, 1.25 mV per step.
// R15 - Processor sets digital data thresholds 20 mV apart for hysteresis.
// R16 - Input latch sets above upper threshold, resets below lower, else holds.
// R17 - Processor initialises the input, then raises arm to start pretrigger loading.
// R18 - Eight write locations decoded from three address bits.
// R19 - Eight read locations return one status bit in bit 7, mode in 5..0.
// R20 - Trigger plus completed delay countdown halts the sample memory.
// R21 - Hold switches b and c gate the DAC onto their own capacitors.
`timescale 1ns/1ps
module aic_input_control import aic_pkg::*; #(
   parameter int unsigned MEM_DEPTH = AIC_MEM_BITS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire aic_bus_t bus,
   input wire logic [5:0] modeState,
   input wire logic dataUpper,
   input wire logic dataLower,
   input wire logic extTrigIn,
   input wire logic compE,
   input wire logic compF,
   input wire logic monitorIn,
   output logic [7:0] rdData,
   output logic [11:0] dacCode,
   output aic_switch_t switches,
   output logic dotDetectEnable,
   output logic compStrobe,
   output logic sampleTick,
   output logic armed,
   output logic triggered,
   output logic memHalted,
   output logic memReadBit
);
   localparam int AW = $clog2(MEM_DEPTH);

   typedef enum logic [2:0] {
      AIC_ST_IDLE = 3'b001,
      AIC_ST_ARMED = 3'b010,
      AIC_ST_HALT = 3'b100
   } aic_state_t;

   logic [5:0] dacLo_reg, dacLo_next;
   logic [5:0] dacHi_reg, dacHi_next;
   logic [3:0] sw_reg, sw_next;
   logic [5:0] clkSel_reg, clkSel_next;
   logic [4:0] trigCtl_reg, trigCtl_next;
   logic [15:0] delay_reg, delay_next;
   logic [AW-1:0] wrPtr_reg, wrPtr_next;
   logic [AW-1:0] rdPtr_reg, rdPtr_next;
   logic inLatch_reg, inLatch_next;
   logic trigFlag_reg, trigFlag_next;
   logic endFlag_reg, endFlag_next;
   logic strobeFlag_reg, strobeFlag_next;
   logic [2:0] div5_reg, div5_next;
   logic div2_reg, div2_next;
   logic tick_reg, tick_next;
   logic dataPrev_reg, extPrev_reg;
   logic [7:0] rdData_reg, rdData_next;
   aic_state_t state_reg, state_next;
   logic [AIC_DECADES-1:0] decTick;
   logic decadeTick;
   logic trigEvent;
   logic dataSrc;
   logic memBit;
   logic memBit_q;
   logic wrLoLoad, wrHiLoad, memClkStrobe;

   aic_decade_chain #(.STAGES(AIC_DECADES)) uDecade (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .tick(decTick)
   );

   aic_sample_mem #(.DEPTH(MEM_DEPTH)) uMem (
      .ref_clk(ref_clk),
      .wrEn(state_reg != AIC_ST_HALT && tick_reg),
      .wrAddr(wrPtr_reg),
      .wrBit(memBit),
      .rdAddr(rdPtr_reg),
      .rdBit(memBit_q)
   );

   // Selected decade tick, then the 1, 2 or 5 prescaler.
   assign decadeTick = decTick[clkSel_reg[2:0]]; // R1

   // Analog modes see the strobed sample, digital modes see the hysteresis latch.
   assign dataSrc = clkSel_reg[AIC_F_DOT] ? dataUpper : inLatch_reg; // R7
   assign memBit = dataSrc;

   assign wrLoLoad = bus.wrStrobe && bus.addr == AIC_WR_DLY_LO;
   assign wrHiLoad = bus.wrStrobe && bus.addr == AIC_WR_DLY_HI;
   assign memClkStrobe = bus.wrStrobe && bus.addr == AIC_WR_MEMCLK;

   always_comb begin
      unique case (trigCtl_reg[1:0]) // R5
         2'h0: trigEvent = dataUpper && !dataPrev_reg;
         2'h1: trigEvent = !dataUpper && dataPrev_reg;
         2'h2: trigEvent = extTrigIn && !extPrev_reg;
         2'h3: trigEvent = !extTrigIn && extPrev_reg;
      endcase
      if (trigCtl_reg[AIC_F_MANUAL]) begin
         trigEvent = 1'b1;
      end
   end

   // Write latches decoded from the three address bits.
   always_comb begin
      dacLo_next = dacLo_reg;
      dacHi_next = dacHi_reg;
      sw_next = sw_reg;
      clkSel_next = clkSel_reg;
      trigCtl_next = trigCtl_reg;
      if (bus.wrStrobe) begin
         unique case (bus.addr) // R18
            AIC_WR_DAC_LO: dacLo_next = bus.wrData[5:0];
            AIC_WR_DAC_HI: dacHi_next = bus.wrData[5:0];
            AIC_WR_SWITCH: sw_next = bus.wrData[3:0]; // R21
            AIC_WR_CLKSEL: clkSel_next = bus.wrData[5:0]; // R6
            AIC_WR_TRIG: trigCtl_next = bus.wrData[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dacLo_reg <= 6'h00;
         dacHi_reg <= 6'h20;
         sw_reg <= 4'h0;
         clkSel_reg <= 6'h00;
         trigCtl_reg <= 5'h00;
      end else begin
         dacLo_reg <= dacLo_next;
         dacHi_reg <= dacHi_next;
         sw_reg <= sw_next;
         clkSel_reg <= clkSel_next;
         trigCtl_reg <= trigCtl_next;
      end
   end

   // Prescaler producing the one-cycle sample tick.
   always_comb begin
      div2_next = div2_reg;
      div5_next = div5_reg;
      tick_next = 1'b0;
      if (decadeTick) begin
         div2_next = !div2_reg;
         div5_next = (div5_reg == AIC_DIV5_TOP) ? 3'h0 : div5_reg + 3'h1;
         unique case (clkSel_reg[4:3]) // R2
            2'h1: tick_next = div2_reg;
            2'h2: tick_next = div5_reg == AIC_DIV5_TOP;
            default: tick_next = 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div2_reg <= 1'b0;
         div5_reg <= 3'h0;
         tick_reg <= 1'b0;
         dataPrev_reg <= 1'b0;
         extPrev_reg <= 1'b0;
      end else begin
         div2_reg <= div2_next;
         div5_reg <= div5_next;
         tick_reg <= tick_next;
         dataPrev_reg <= dataUpper;
         extPrev_reg <= extTrigIn;
      end
   end

   // Hysteresis latch; upper crossing wins if both comparators disagree.
   always_comb begin
      inLatch_next = inLatch_reg;
      if (dataUpper) begin
         inLatch_next = 1'b1; // R16
      end else if (!dataLower) begin
         inLatch_next = 1'b0; // R16
      end
   end

   // Acquisition sequence: arm, wait for trigger, count down, halt.
   always_comb begin
      state_next = state_reg;
      delay_next = delay_reg;
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      trigFlag_next = trigFlag_reg;
      endFlag_next = endFlag_reg;
      strobeFlag_next = strobeFlag_reg;
      if (wrLoLoad) begin
         delay_next[7:0] = bus.wrData; // R4
      end
      if (wrHiLoad) begin
         delay_next[15:8] = bus.wrData; // R4
      end
      if (memClkStrobe) begin
         rdPtr_next = rdPtr_reg + 1'b1;
         strobeFlag_next = !strobeFlag_reg;
      end
      unique case (state_reg)
         AIC_ST_IDLE: begin
            if (trigCtl_reg[AIC_F_ARM]) begin
               state_next = AIC_ST_ARMED;
               trigFlag_next = 1'b0;
               endFlag_next = 1'b0;
            end
         end
         AIC_ST_ARMED: begin
            if (tick_reg) begin
               wrPtr_next = wrPtr_reg + 1'b1;
            end
            if (trigEvent) begin
               trigFlag_next = 1'b1;
            end
            // Counts up from the complement so all-ones marks the end.
            if (trigFlag_reg && tick_reg) begin
               if (delay_reg == AIC_DELAY_DONE) begin
                  state_next = AIC_ST_HALT; // R20
                  endFlag_next = 1'b1;
                  rdPtr_next = wrPtr_reg;
               end else if (!wrLoLoad && !wrHiLoad) begin
                  delay_next = delay_reg + 16'h0001; // R3
               end
            end
            if (!trigCtl_reg[AIC_F_ARM]) begin
               state_next = AIC_ST_IDLE;
            end
         end
         AIC_ST_HALT: begin
            if (!trigCtl_reg[AIC_F_ARM]) begin
               state_next = AIC_ST_IDLE;
            end
         end
         default: state_next = AIC_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= AIC_ST_IDLE;
         delay_reg <= 16'h0000;
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         trigFlag_reg <= 1'b0;
         endFlag_reg <= 1'b0;
         strobeFlag_reg <= 1'b0;
         inLatch_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         delay_reg <= delay_next;
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         trigFlag_reg <= trigFlag_next;
         endFlag_reg <= endFlag_next;
         strobeFlag_reg <= strobeFlag_next;
         inLatch_reg <= inLatch_next;
      end
   end

   // Read data is registered; status bit 7 differs by location.
   always_comb begin
      rdData_next = rdData_reg;
      if (bus.rdStrobe) begin
         rdData_next = {2'b00, modeState}; // R19
         unique case (bus.addr)
            AIC_RD_CMP_A: rdData_next[AIC_F_STATUS] = dataUpper;
            AIC_RD_CMP_C: rdData_next[AIC_F_STATUS] = dataLower;
            AIC_RD_CMP_E: rdData_next[AIC_F_STATUS] = compE;
            AIC_RD_CMP_F: rdData_next[AIC_F_STATUS] = compF;
            AIC_RD_TRIG: rdData_next[AIC_F_STATUS] = trigFlag_reg;
            AIC_RD_END: rdData_next[AIC_F_STATUS] = endFlag_reg;
            AIC_RD_STROBE: rdData_next[AIC_F_STATUS] = strobeFlag_reg;
            AIC_RD_MON: rdData_next[AIC_F_STATUS] = monitorIn;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_reg <= 8'h00;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   // Output flops.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdData <= 8'h00;
         dacCode <= AIC_DAC_ZERO;
         switches <= '0;
         dotDetectEnable <= 1'b0;
         compStrobe <= 1'b1;
         sampleTick <= 1'b0;
         armed <= 1'b0;
         triggered <= 1'b0;
         memHalted <= 1'b0;
         memReadBit <= 1'b0;
      end else begin
         rdData <= rdData_next;
         dacCode <= {dacHi_next, dacLo_next}; // R14
         switches <= '{holdSwitchA: sw_next[AIC_F_HOLD_A], holdSwitchB: sw_next[AIC_F_HOLD_B],
                       holdSwitchC: sw_next[AIC_F_HOLD_C], inputGroundSelect: sw_next[AIC_F_GROUND]}; // R21
         dotDetectEnable <= clkSel_next[AIC_F_DOT]; // R6
         compStrobe <= clkSel_next[AIC_F_DOT] ? tick_next : 1'b1; // R7
         sampleTick <= tick_next;
         armed <= state_next == AIC_ST_ARMED;
         triggered <= trigFlag_next;
         memHalted <= state_next == AIC_ST_HALT; // R20
         memReadBit <= memBit_q;
      end
   end
endmodule // aic_input_control

// ==== verilog/aic_pkg.sv ====
// Shared constants and types for the acquisition input control block.
package aic_pkg;
   localparam int unsigned AIC_REF_HZ = 100_000_000;
   localparam int unsigned AIC_DECADES = 8;
   localparam int unsigned AIC_MEM_BITS = 1024;
   localparam logic [2:0] AIC_WR_DAC_LO = 3'h0;
   localparam logic [2:0] AIC_WR_DAC_HI = 3'h1;
   localparam logic [2:0] AIC_WR_SWITCH = 3'h2;
   localparam logic [2:0] AIC_WR_CLKSEL = 3'h3;
   localparam logic [2:0] AIC_WR_TRIG = 3'h4;
   localparam logic [2:0] AIC_WR_DLY_LO = 3'h5;
   localparam logic [2:0] AIC_WR_DLY_HI = 3'h6;
   localparam logic [2:0] AIC_WR_MEMCLK = 3'h7;
   localparam logic [2:0] AIC_RD_CMP_A = 3'h0;
   localparam logic [2:0] AIC_RD_CMP_C = 3'h1;
   localparam logic [2:0] AIC_RD_CMP_E = 3'h2;
   localparam logic [2:0] AIC_RD_CMP_F = 3'h3;
   localparam logic [2:0] AIC_RD_TRIG = 3'h4;
   localparam logic [2:0] AIC_RD_END = 3'h5;
   localparam logic [2:0] AIC_RD_STROBE = 3'h6;
   localparam logic [2:0] AIC_RD_MON = 3'h7;
   localparam int AIC_F_HOLD_A = 0;
   localparam int AIC_F_HOLD_B = 1;
   localparam int AIC_F_HOLD_C = 2;
   localparam int AIC_F_GROUND = 3;
   localparam int AIC_F_DOT = 5;
   localparam int AIC_F_MANUAL = 4;
   localparam int AIC_F_ARM = 3;
   localparam int AIC_F_STATUS = 7;
   localparam logic [11:0] AIC_DAC_ZERO = 12'h800;
   localparam logic [2:0] AIC_PRE_NONE = 3'h1;
   localparam logic [2:0] AIC_PRE_DIV2 = 3'h2;
   localparam logic [2:0] AIC_PRE_DIV5 = 3'h4;
   localparam logic [3:0] AIC_DECADE_TOP = 4'h9;
   localparam logic [2:0] AIC_DIV5_TOP = 3'h4;
   localparam logic [15:0] AIC_DELAY_DONE = 16'hFFFF;

   typedef struct packed {
      logic wrStrobe;
      logic rdStrobe;
      logic [2:0] addr;
      logic [7:0] wrData;
   } aic_bus_t;

   typedef struct packed {
      logic holdSwitchA;
      logic holdSwitchB;
      logic holdSwitchC;
      logic inputGroundSelect;
   } aic_switch_t;
endpackage

// ==== verilog/aic_decade_chain.sv ====
// Decade divider chain producing one clock-enable tick per stage.
`timescale 1ns/1ps
module aic_decade_chain import aic_pkg::*; #(
   parameter int unsigned STAGES = AIC_DECADES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   output logic [STAGES-1:0] tick
);
   logic [3:0] cnt_reg [STAGES];
   logic [STAGES-1:0] carry;

   // Stage 0 ticks every oscillator cycle; each later stage ticks once per ten of the one before.
   assign tick[0] = 1'b1;
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : gStage
         logic [3:0] cntNext;
         assign carry[g] = tick[g] && (cnt_reg[g] == AIC_DECADE_TOP);
         if (g > 0) begin : gTick
            assign tick[g] = carry[g-1];
         end
         always_comb begin
            cntNext = cnt_reg[g];
            if (tick[g]) begin
               cntNext = carry[g] ? 4'h0 : cnt_reg[g] + 4'h1;
            end
         end
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               cnt_reg[g] <= 4'h0;
            end else begin
               cnt_reg[g] <= cntNext;
            end
         end
      end
   endgenerate
endmodule // aic_decade_chain

// ==== verilog/aic_sample_mem.sv ====
// Circular one-bit sample memory with registered read data.
`timescale 1ns/1ps
module aic_sample_mem import aic_pkg::*; #(
   parameter int unsigned DEPTH = AIC_MEM_BITS
) (
   input wire logic ref_clk,
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic wrBit,
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic rdBit
);
   logic memArray [DEPTH];

   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrBit;
      end
      rdBit <= memArray[rdAddr];
   end
endmodule // aic_sample_mem

// ==== test/aic_input_control_props.sv ====
// Port checker for the acquisition input control block.
`timescale 1ns/1ps
module aic_input_control_props import aic_pkg::*; #(
   parameter int unsigned MEM_DEPTH = AIC_MEM_BITS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire aic_bus_t bus,
   input wire logic [5:0] modeState,
   input wire logic dataUpper,
   input wire logic dataLower,
   input wire logic extTrigIn,
   input wire logic compE,
   input wire logic compF,
   input wire logic monitorIn,
   input wire logic [7:0] rdData,
   input wire logic [11:0] dacCode,
   input wire aic_switch_t switches,
   input wire logic dotDetectEnable,
   input wire logic compStrobe,
   input wire logic sampleTick,
   input wire logic armed,
   input wire logic triggered,
   input wire logic memHalted,
   input wire logic memReadBit
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic wr = bus.wrStrobe;
   // The switch struct lists hold A first, so the write bits are reversed.
   wire logic [3:0] swBits = {bus.wrData[0], bus.wrData[1], bus.wrData[2], bus.wrData[3]};
   dac_reset_a: assert property ($rose(resetn) |-> dacCode == AIC_DAC_ZERO)
      else $error("dac code not at midscale after reset");
   dac_low_a: assert property (wr && bus.addr == AIC_WR_DAC_LO |=> dacCode[5:0] == $past(bus.wrData[5:0]))
      else $error("dac low part not loaded");
   dac_high_a: assert property (wr && bus.addr == AIC_WR_DAC_HI |=> dacCode[11:6] == $past(bus.wrData[5:0]))
      else $error("dac high part not loaded");
   switch_load_a: assert property (wr && bus.addr == AIC_WR_SWITCH |=> switches == $past(swBits))
      else $error("switch controls not loaded");
   dot_load_a: assert property (wr && bus.addr == AIC_WR_CLKSEL |=> dotDetectEnable == $past(bus.wrData[AIC_F_DOT]))
      else $error("dot enable not loaded");
   strobe_mode_a: assert property (compStrobe == (dotDetectEnable ? sampleTick : 1'b1))
      else $error("comparator strobe wrong for mode");
   read_mode_a: assert property (bus.rdStrobe |=> rdData[6:0] == {1'b0, $past(modeState)})
      else $error("mode bits wrong on read");
   read_hold_a: assert property (!bus.rdStrobe |=> $stable(rdData))
      else $error("read data moved without a read");
   read_end_a: assert property (bus.rdStrobe && bus.addr == AIC_RD_END |=> rdData[7] == $past(memHalted))
      else $error("end flag wrong on read");
   halt_trig_a: assert property (memHalted |-> triggered)
      else $error("memory halted without trigger");
   halt_c: cover property ($rose(memHalted));
   dot_c: cover property (dotDetectEnable && sampleTick);
   flag_c: cover property (bus.rdStrobe && bus.addr == AIC_RD_STROBE);
endmodule // aic_input_control_props

bind aic_input_control aic_input_control_props #(.MEM_DEPTH(MEM_DEPTH)) props (.ref_clk(ref_clk), .resetn(resetn),
   .bus(bus), .modeState(modeState), .dataUpper(dataUpper), .dataLower(dataLower), .extTrigIn(extTrigIn),
   .compE(compE), .compF(compF), .monitorIn(monitorIn), .rdData(rdData), .dacCode(dacCode), .switches(switches),
   .dotDetectEnable(dotDetectEnable), .compStrobe(compStrobe), .sampleTick(sampleTick), .armed(armed),
   .triggered(triggered), .memHalted(memHalted), .memReadBit(memReadBit));

// ==== test/aic_cpu_model.sv ====
// Processor model driving the input board control bus.
`timescale 1ns/1ps
module aic_cpu_model import aic_pkg::*; (
   input wire logic ref_clk,
   output aic_bus_t bus
);
   initial bus = '0;

   // Released address and data are inverted so stale values never look valid.
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{wrStrobe: w, rdStrobe: ~w, addr: a, wrData: d};
      @(posedge ref_clk);
      bus <= '{wrStrobe: 1'b0, rdStrobe: 1'b0, addr: ~a, wrData: ~d};
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [2:0] a);
      acc(1'b0, a, 8'h00);
   endtask
   task automatic thr(input int ch, input logic [11:0] code);
      wr(AIC_WR_SWITCH, 8'h00);
      wr(AIC_WR_DAC_LO, {2'h0, code[5:0]});
      wr(AIC_WR_DAC_HI, {2'h0, code[11:6]});
      // The DAC output must settle before the capacitor switch closes.
      repeat (4) @(posedge ref_clk);
      wr(AIC_WR_SWITCH, 8'(1 << ch));
      wr(AIC_WR_SWITCH, 8'h00);
   endtask
   task automatic dly(input logic [15:0] n);
      wr(AIC_WR_DLY_LO, ~n[7:0]);
      wr(AIC_WR_DLY_HI, ~n[15:8]);
   endtask
endmodule // aic_cpu_model

// ==== test/tb.sv ====
// Self-checking testbench for the acquisition input control block.
`timescale 1ns/1ps
module tb import aic_pkg::*; ;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   aic_bus_t bus;
   logic [5:0] modeState = 6'h00;
   logic dataUpper = 1'b0;
   logic dataLower = 1'b0;
   logic extTrigIn = 1'b0;
   logic compE = 1'b0;
   logic compF = 1'b0;
   logic monitorIn = 1'b0;
   logic [7:0] rdData;
   logic [11:0] dacCode;
   aic_switch_t switches;
   logic dotDetectEnable, compStrobe, sampleTick, armed, triggered, memHalted, memReadBit;
   logic [31:0] seed = 32'h0AA4924D;
   logic [7:0] expQ[$];
   logic rdSeen = 1'b0;
   int n_errors = 0;
   int check_count = 0;
   wire logic [2:0] flags = {memHalted, triggered, sampleTick};

   initial forever #5 ref_clk = ~ref_clk;

   aic_cpu_model cpu (.ref_clk(ref_clk), .bus(bus));
   aic_input_control dut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .modeState(modeState),
      .dataUpper(dataUpper), .dataLower(dataLower), .extTrigIn(extTrigIn), .compE(compE), .compF(compF),
      .monitorIn(monitorIn), .rdData(rdData), .dacCode(dacCode), .switches(switches),
      .dotDetectEnable(dotDetectEnable), .compStrobe(compStrobe), .sampleTick(sampleTick), .armed(armed),
      .triggered(triggered), .memHalted(memHalted), .memReadBit(memReadBit));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic await(input int w, input int lim, output int i);
      i = 0;
      while (flags[w] !== 1'b1 && i < lim) begin
         @(negedge ref_clk);
         i++;
      end
      if (flags[w] !== 1'b1) begin
         check(flags[w], 1'b1);
         results();
      end
   endtask
   // The expectation is queued before the strobe so the monitor never runs ahead.
   task automatic rdx(input logic [2:0] a, input logic st);
      logic [31:0] r;
      r = rnd();
      @(posedge ref_clk);
      modeState <= r[5:0];
      expQ.push_back({st, 1'b0, r[5:0]});
      cpu.rd(a);
   endtask

   always @(posedge ref_clk) rdSeen <= bus.rdStrobe;
   always @(negedge ref_clk) begin
      if (rdSeen) begin
         check(rdData, expQ.pop_front());
      end
   end

   initial begin
      int n;
      int div;
      logic [11:0] c;
      logic [11:0] off;
      logic [7:0] st;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      check(dacCode, AIC_DAC_ZERO);
      check({switches, dotDetectEnable, compStrobe, armed, triggered, memHalted}, 9'h008);
      $display("test reset done");
      cpu.wr(AIC_WR_SWITCH, 8'h08);
      @(negedge ref_clk);
      check(switches, 4'h1);
      // Offsets stay inside fifty millivolts, forty DAC steps, so every input counts as calibrated.
      off = 12'(rnd() % 32'h51) - 12'h028;
      c = AIC_DAC_ZERO + 12'(rnd() % 32'h3E8) + off;
      for (int ch = 0; ch < 3; ch++) begin
         cpu.thr(ch, ch == 1 ? c - 12'h010 : c);
         check(dacCode, ch == 1 ? c - 12'h010 : c);
      end
      for (int k = 0; k < 2; k++) begin
         st = 8'(rnd()) & 8'h8F;
         @(posedge ref_clk);
         {monitorIn, compF, compE, dataLower, dataUpper} <= {st[7], st[3:0]};
         for (int a = 0; a < 8; a++) rdx(3'(a), st[a]);
      end
      cpu.wr(AIC_WR_MEMCLK, 8'h00);
      rdx(AIC_RD_STROBE, 1'b1);
      $display("test registers done");
      for (int d = 0; d < 3; d++) begin
         for (int p = 0; p < 4; p++) begin
            div = (d == 0 ? 1 : d == 1 ? 10 : 100) * (p == 1 ? 2 : p == 2 ? 5 : 1);
            cpu.wr(AIC_WR_CLKSEL, 8'(p * 8 + d + (p % 2) * 32));
            // The first tick may still follow the old setting and the next gap may be short.
            // Only the third interval is a clean period of the new setting.
            repeat (3) begin
               @(negedge ref_clk);
               await(0, 600, n);
            end
            check(16'(n + 1), 16'(div));
            @(negedge ref_clk);
            check(dotDetectEnable, 16'(p % 2));
            check(compStrobe, 16'(p % 2 == 0 || div == 1));
         end
      end
      cpu.wr(AIC_WR_CLKSEL, 8'h00);
      $display("test sample clock done");
      for (int s = 0; s < 5; s++) begin
         div = 6 + 3 * s;
         @(posedge ref_clk);
         dataUpper <= s == 0;
         dataLower <= 1'b0;
         extTrigIn <= s == 2;
         cpu.dly(16'(div));
         cpu.wr(AIC_WR_TRIG, 8'(8 + s % 4));
         if (s < 4) begin
            repeat (2) begin
               repeat (3) @(negedge ref_clk);
               check(triggered, 1'b0);
               @(posedge ref_clk);
               {dataUpper, extTrigIn} <= s < 2 ? {~dataUpper, extTrigIn} : {dataUpper, ~extTrigIn};
            end
         end else begin
            cpu.wr(AIC_WR_TRIG, 8'h18);
         end
         @(negedge ref_clk);
         await(1, 20, n);
         await(2, 100, n);
         check(16'(n + 3 >= div && n <= div + 3), 16'h1);
         rdx(AIC_RD_END, 1'b1);
         rdx(AIC_RD_TRIG, 1'b1);
         // The halted slot holds the latch state, which is set only while the input sits high.
         check(memReadBit, 16'(s == 0));
         cpu.wr(AIC_WR_TRIG, 8'h00);
         // Disarming takes two edges; the trigger flag is kept until the next arm.
         repeat (2) @(negedge ref_clk);
         check({armed, triggered, memHalted}, 3'h2);
      end
      $display("test trigger done");
      repeat (4) @(negedge ref_clk);
      results();
   end
endmodule // tb
